// ===== pkg/ttd_pkg.sv
`default_nettype none
package ttd_pkg;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned SAMPLE_W = 16;
    localparam int unsigned CNT_W = 12;
    localparam int unsigned DLY_DEPTH = 1024;
    localparam int unsigned DLY_AW = 10;
    localparam int unsigned DEBOUNCE_SAMPLES = 3;
    localparam int unsigned DEB_W = 2;

    // register byte addresses
    localparam logic [11:0] ADDR_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_THR_HI  = 12'h004;
    localparam logic [11:0] ADDR_THR_LO  = 12'h008;
    localparam logic [11:0] ADDR_RANGE   = 12'h00C;
    localparam logic [11:0] ADDR_OFFSET  = 12'h010;
    localparam logic [11:0] ADDR_TM1     = 12'h014;
    localparam logic [11:0] ADDR_TM2     = 12'h018;
    localparam logic [11:0] ADDR_STATUS  = 12'h01C;
    localparam logic [11:0] ADDR_IRQ_ST  = 12'h020;
    localparam logic [11:0] ADDR_IRQ_MSK = 12'h024;

    // control field positions
    localparam int unsigned CTRL_FEAT_LSB = 0;
    localparam int unsigned CTRL_CHAN_LSB = 4;
    localparam int unsigned CTRL_SYNC_LSB = 8;
    localparam int unsigned CTRL_HYST_BIT = 12;
    localparam int unsigned CTRL_DEN_BIT  = 13;
    localparam int unsigned CTRL_ENHID_BIT = 14;
    localparam int unsigned CTRL_EN_BIT   = 15;
    localparam int unsigned CTRL_EVF_BIT  = 16;
    localparam int unsigned CTRL_EVP_BIT  = 17;
    localparam int unsigned CTRL_SNIP_BIT = 18;

    // interrupt bit positions
    localparam int unsigned IRQ_FEAT = 0;
    localparam int unsigned IRQ_PASS = 1;
    localparam int unsigned IRQ_FAIL = 2;
    localparam int unsigned IRQ_W = 3;

    typedef enum logic [2:0]
    {
        TTD_ABOVE   = 3'h0,
        TTD_BELOW   = 3'h1,
        TTD_BETWEEN = 3'h2,
        TTD_OUTSIDE = 3'h3,
        TTD_RISING  = 3'h4,
        TTD_FALLING = 3'h5
    } ttd_feat_e;

    typedef enum logic [1:0]
    {
        TTD_SYNC_FEAT = 2'h0,
        TTD_SYNC_EXT  = 2'h1,
        TTD_SYNC_NONE = 2'h2
    } ttd_sync_e;

    typedef enum logic [3:0]
    {
        TTD_IDLE  = 4'h1,
        TTD_PRE   = 4'h2,
        TTD_POST  = 4'h4,
        TTD_STROBE = 4'h8
    } ttd_state_e;

    typedef struct packed
    {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ttd_apb_req_s;

    typedef struct packed
    {
        logic        feature_state;
        logic        trigger;
        logic        strobe;
        logic        sync_mark;
        logic        ev_feature;
        logic        ev_pass;
        logic        snip_req;
    } ttd_events_s;

    localparam logic [31:0] CTRL_RESET = 32'h0000_4000;
endpackage
`default_nettype wire

// ===== src/ttd_detector.sv
// How it works
// - above/below compare selected sample against the single threshold.
// - between/outside compare against upper and lower thresholds.
// - feature type resets to above.
// - four channels in, one selected for detection, all forwarded on pass.
// - hysteresis needs false for tm1 before crossing, true for tm2 after.
// - trigger high exactly one sample when all conditions pass.
// - a failing hysteresis candidate gives no trigger.
// - delayed waveform lags by range plus offset without hysteresis.
// - with hysteresis the lag adds time marker two.
// - debounce needs three consecutive true samples.
// - with visible enable, trigger and strobe wait for enable.
// - hidden enable (default) means outputs always enabled.
// - window origin from feature, external sync, or none.
// - optional feature/pass events and snippet request on trigger.
// - feature state high while the condition holds.
// - strobe high from trigger for the window range.
`default_nettype none
module ttd_detector
    import ttd_pkg::*;
(
    // clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         reset,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // sample stream
    input  wire logic [NUM_CH*SAMPLE_W-1:0]   sample_in,
    input  wire logic                         ext_sync,
    // outputs
    output logic                              feature_state,
    output logic                              trigger,
    output logic                              strobe,
    output logic                              sync_mark,
    output logic [NUM_CH*SAMPLE_W-1:0]        delayed_waveform_out,
    output logic [NUM_CH*SAMPLE_W-1:0]        store_waveform,
    output logic                              store_valid,
    output logic                              ev_feature,
    output logic                              ev_pass,
    output logic                              snip_req,
    output logic                              irq
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed
    {
        logic [31:0]             ctrl;
        logic [SAMPLE_W-1:0]     thr_hi;
        logic [SAMPLE_W-1:0]     thr_lo;
        logic [CNT_W-1:0]        range;
        logic [CNT_W-1:0]        offset;
        logic [CNT_W-1:0]        tm1;
        logic [CNT_W-1:0]        tm2;
        logic [IRQ_W-1:0]        irq_st;
        logic [IRQ_W-1:0]        irq_msk;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
        logic [SAMPLE_W-1:0]     prev;
        logic [DEB_W-1:0]        deb;
        logic                    feat;
        ttd_state_e              st;
        logic [CNT_W-1:0]        cnt;
        logic [DLY_AW-1:0]       wptr;
        logic [NUM_CH*SAMPLE_W-1:0] dly;
        logic                    irq;
        logic                    store_valid;
        ttd_events_s             ev;
    } ttd_state_s;

    ttd_state_s state_reg;
    ttd_state_s state_next;

    logic [NUM_CH*SAMPLE_W-1:0] dly_mem [DLY_DEPTH];
    logic [NUM_CH*SAMPLE_W-1:0] dly_rd;

    // ****************************************
    // combinational
    // ****************************************
    ttd_feat_e               feat_type;
    ttd_sync_e               sync_sel;
    logic [1:0]              chan;
    logic                    hyst_en;
    logic                    den_en;
    logic                    enable_ok;
    logic [SAMPLE_W-1:0]     cur;
    logic                    raw;
    logic                    feat_now;
    logic                    rise;
    logic                    fire;
    logic                    failed;
    logic [CNT_W-1:0]        lag;
    logic [DLY_AW-1:0]       rptr;
    logic                    acc;

    assign feat_type = ttd_feat_e'(state_reg.ctrl[CTRL_FEAT_LSB +: 3]);
    assign sync_sel  = ttd_sync_e'(state_reg.ctrl[CTRL_SYNC_LSB +: 2]);
    assign chan      = state_reg.ctrl[CTRL_CHAN_LSB +: 2];
    assign hyst_en   = state_reg.ctrl[CTRL_HYST_BIT];
    assign den_en    = state_reg.ctrl[CTRL_DEN_BIT];
    assign enable_ok = state_reg.ctrl[CTRL_ENHID_BIT] | state_reg.ctrl[CTRL_EN_BIT];
    assign cur = sample_in[chan*SAMPLE_W +: SAMPLE_W];
    assign lag  = hyst_en ? CNT_W'(state_reg.range + state_reg.offset + state_reg.tm2)
                          : CNT_W'(state_reg.range + state_reg.offset);
    assign rptr = DLY_AW'(state_reg.wptr - lag[DLY_AW-1:0]);
    assign dly_rd = dly_mem[rptr];
    assign acc = psel & penable & ~state_reg.pready;

    always_comb
    begin
        case (feat_type)
            TTD_ABOVE:   raw = cur > state_reg.thr_hi;
            TTD_BELOW:   raw = cur < state_reg.thr_hi;
            TTD_BETWEEN: raw = (cur < state_reg.thr_hi) && (cur > state_reg.thr_lo);
            TTD_OUTSIDE: raw = (cur > state_reg.thr_hi) || (cur < state_reg.thr_lo);
            TTD_RISING:  raw = cur > state_reg.prev;
            TTD_FALLING: raw = cur < state_reg.prev;
            default:     raw = 1'b0;
        endcase
    end

    always_comb
    begin
        state_next = state_reg;
        fire = 1'b0;
        failed = 1'b0;
        state_next.prev = cur;
        if (!raw)
            state_next.deb = '0;
        else if (state_reg.deb != DEB_W'(DEBOUNCE_SAMPLES - 1))
            state_next.deb = DEB_W'(state_reg.deb + 1'b1);
        feat_now = den_en ? (raw && state_reg.deb == DEB_W'(DEBOUNCE_SAMPLES - 1)) : raw;
        state_next.feat = feat_now;
        rise = feat_now & ~state_reg.feat;

        state_next.cnt = CNT_W'(state_reg.cnt + 1'b1);
        case (state_reg.st)
            TTD_IDLE:
            begin
                if (!hyst_en)
                begin
                    if (rise)
                        fire = 1'b1;
                end
                else if (!feat_now)
                begin
                    state_next.st = TTD_PRE;
                    state_next.cnt = '0;
                end
            end
            TTD_PRE:
            begin
                if (!hyst_en)
                    state_next.st = TTD_IDLE;
                else if (feat_now)
                begin
                    if (state_reg.cnt >= state_reg.tm1)
                    begin
                        state_next.st = TTD_POST;
                        state_next.cnt = '0;
                    end
                    else
                        state_next.cnt = '0;
                end
            end
            TTD_POST:
            begin
                if (!feat_now)
                begin
                    failed = 1'b1;
                    state_next.st = TTD_PRE;
                    state_next.cnt = '0;
                end
                else if (state_reg.cnt + 1'b1 >= state_reg.tm2)
                    fire = 1'b1;
            end
            TTD_STROBE:
            begin
                if (state_reg.cnt + 1'b1 >= state_reg.range)
                    state_next.st = TTD_IDLE;
            end
            default:
                state_next.st = TTD_IDLE;
        endcase
        if (fire)
        begin
            state_next.st = TTD_STROBE;
            state_next.cnt = '0;
        end
        state_next.ev.trigger = fire & enable_ok;
        state_next.ev.strobe = enable_ok & (fire | (state_reg.st == TTD_STROBE
                               && state_reg.cnt + 1'b1 < state_reg.range));
        state_next.ev.feature_state = feat_now;
        case (sync_sel)
            TTD_SYNC_FEAT: state_next.ev.sync_mark = rise;
            TTD_SYNC_EXT:  state_next.ev.sync_mark = ext_sync;
            default:       state_next.ev.sync_mark = 1'b0;
        endcase
        state_next.ev.ev_feature = rise & state_reg.ctrl[CTRL_EVF_BIT];
        state_next.ev.ev_pass = fire & enable_ok & state_reg.ctrl[CTRL_EVP_BIT];
        state_next.ev.snip_req = fire & enable_ok & state_reg.ctrl[CTRL_SNIP_BIT];
        state_next.store_valid = state_next.ev.strobe;

        // delay line
        state_next.wptr = DLY_AW'(state_reg.wptr + 1'b1);
        state_next.dly = dly_rd;

        // interrupts: set wins over clear
        state_next.pready = acc;
        state_next.pslverr = 1'b0;
        if (acc && pwrite && paddr == ADDR_IRQ_ST)
            state_next.irq_st = state_reg.irq_st & ~pwdata[IRQ_W-1:0];
        state_next.irq_st[IRQ_FEAT] = state_next.irq_st[IRQ_FEAT] | rise;
        state_next.irq_st[IRQ_PASS] = state_next.irq_st[IRQ_PASS] | fire;
        state_next.irq_st[IRQ_FAIL] = state_next.irq_st[IRQ_FAIL] | failed;

        // apb decode
        if (acc)
        begin
            if (pwrite)
            begin
                if (paddr == ADDR_CTRL)
                    state_next.ctrl = pwdata;
                else if (paddr == ADDR_THR_HI)
                    state_next.thr_hi = pwdata[SAMPLE_W-1:0];
                else if (paddr == ADDR_THR_LO)
                    state_next.thr_lo = pwdata[SAMPLE_W-1:0];
                else if (paddr == ADDR_RANGE)
                    state_next.range = pwdata[CNT_W-1:0];
                else if (paddr == ADDR_OFFSET)
                    state_next.offset = pwdata[CNT_W-1:0];
                else if (paddr == ADDR_TM1)
                    state_next.tm1 = pwdata[CNT_W-1:0];
                else if (paddr == ADDR_TM2)
                    state_next.tm2 = pwdata[CNT_W-1:0];
                else if (paddr == ADDR_IRQ_MSK)
                    state_next.irq_msk = pwdata[IRQ_W-1:0];
                else if (paddr != ADDR_IRQ_ST && paddr != ADDR_STATUS)
                    state_next.pslverr = 1'b1;
            end
            else
            begin
                state_next.prdata = '0;
                if (paddr == ADDR_CTRL)
                    state_next.prdata = state_reg.ctrl;
                else if (paddr == ADDR_THR_HI)
                    state_next.prdata[SAMPLE_W-1:0] = state_reg.thr_hi;
                else if (paddr == ADDR_THR_LO)
                    state_next.prdata[SAMPLE_W-1:0] = state_reg.thr_lo;
                else if (paddr == ADDR_RANGE)
                    state_next.prdata[CNT_W-1:0] = state_reg.range;
                else if (paddr == ADDR_OFFSET)
                    state_next.prdata[CNT_W-1:0] = state_reg.offset;
                else if (paddr == ADDR_TM1)
                    state_next.prdata[CNT_W-1:0] = state_reg.tm1;
                else if (paddr == ADDR_TM2)
                    state_next.prdata[CNT_W-1:0] = state_reg.tm2;
                else if (paddr == ADDR_STATUS)
                    state_next.prdata[5:0] = {state_reg.ev.strobe, state_reg.feat,
                                              state_reg.st};
                else if (paddr == ADDR_IRQ_ST)
                    state_next.prdata[IRQ_W-1:0] = state_reg.irq_st;
                else if (paddr == ADDR_IRQ_MSK)
                    state_next.prdata[IRQ_W-1:0] = state_reg.irq_msk;
                else
                    state_next.pslverr = 1'b1;
            end
        end
        state_next.irq = |(state_next.irq_st & state_next.irq_msk);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= '0;
            state_reg.ctrl <= CTRL_RESET;
            state_reg.st <= TTD_IDLE;
        end
        else
            state_reg <= state_next;
    end

    always_ff @(posedge sys_clk)
    begin
        dly_mem[state_reg.wptr] <= sample_in;
    end

    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign feature_state = state_reg.ev.feature_state;
    assign trigger = state_reg.ev.trigger;
    assign strobe = state_reg.ev.strobe;
    assign sync_mark = state_reg.ev.sync_mark;
    assign ev_feature = state_reg.ev.ev_feature;
    assign ev_pass = state_reg.ev.ev_pass;
    assign snip_req = state_reg.ev.snip_req;
    assign irq = state_reg.irq;
    assign store_valid = state_reg.store_valid;
    assign store_waveform = state_reg.dly;
    assign delayed_waveform_out = state_reg.dly;

    // ****************************************
    // checks
    // ****************************************
    chk_trigger_one_cycle: assert property (@(posedge sys_clk) disable iff (reset)
        trigger |=> !trigger) else $error("trigger longer than one cycle");
    chk_trigger_strobe: assert property (@(posedge sys_clk) disable iff (reset)
        trigger |-> strobe) else $error("strobe not high with trigger");
    chk_enable_gate: assert property (@(posedge sys_clk) disable iff (reset)
        !$past(enable_ok) |-> !trigger && !strobe) else $error("output while disabled");
    chk_feature_level: assert property (@(posedge sys_clk) disable iff (reset)
        !$past(den_en) |-> feature_state == $past(raw)) else $error("feature level mismatch");
    chk_no_retrigger: assert property (@(posedge sys_clk) disable iff (reset)
        $past(strobe) |-> !trigger) else $error("retrigger in window");
    chk_fail_no_trig: assert property (@(posedge sys_clk) disable iff (reset)
        failed |=> !trigger) else $error("trigger after failed candidate");
    chk_hyst_candidate: assert property (@(posedge sys_clk) disable iff (reset)
        $past(hyst_en) && trigger |-> feature_state && $past(feature_state))
        else $error("hysteresis trigger without held feature");
    chk_debounce_len: assert property (@(posedge sys_clk) disable iff (reset)
        den_en && state_next.feat && !state_reg.feat |-> raw && $past(raw) && $past(raw, 2))
        else $error("debounce too short");
    chk_snip_on_trig: assert property (@(posedge sys_clk) disable iff (reset)
        snip_req |-> trigger) else $error("snippet without trigger");
endmodule
`default_nettype wire

// ===== test/ttd_store_model.sv
`default_nettype none
module ttd_store_model
    import ttd_pkg::*;
(
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       reset,
    // storage stream
    input  wire logic                       store_valid,
    input  wire logic [NUM_CH*SAMPLE_W-1:0] store_waveform,
    // capture record
    output var int                          words,
    output logic      [NUM_CH*SAMPLE_W-1:0] first_word
);
    timeunit 1ns;
    timeprecision 1ps;

    logic prev_valid;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            words      <= 0;
            first_word <= '0;
            prev_valid <= 1'b0;
        end
        else
        begin
            prev_valid <= store_valid;
            if (store_valid)
                words <= words + 1;
            if (store_valid && !prev_valid)
                first_word <= store_waveform;
        end
    end
endmodule
`default_nettype wire

// ===== test/threshold_trigger_detector_bench.sv
`default_nettype none
module threshold_trigger_detector_bench
    import ttd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************
    // signals
    // ****************
    localparam logic [47:0] CHI = 48'h0D44_0C33_0B22;
    localparam logic [31:0] HID = 32'h0000_4000;
    localparam logic [31:0] ENA = 32'h0000_8000;
    localparam logic [31:0] HYS = 32'h0000_1000;
    localparam logic [31:0] DEN = 32'h0000_2000;
    localparam logic [31:0] EVX = 32'h0007_0000;
    localparam logic [15:0] HI  = 16'h0800;

    logic        sys_clk   = 1'b0;
    logic        reset     = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0;
    logic [63:0] sample_in = 64'h0;
    logic        ext_sync  = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, feature_state, trigger, strobe, sync_mark;
    logic        store_valid, ev_feature, ev_pass, snip_req, irq;
    logic [63:0] delayed_waveform_out;
    logic [63:0] store_waveform;
    logic [63:0] first_word;
    logic [31:0] rv;
    logic        sv;
    logic        tprev = 1'b0;
    int          words, err_count, cmp_count, run, last_run, dbl, nh, nn;
    int          trig_cnt, str_cnt, evf_cnt, evp_cnt, snp_cnt, fs_cnt, sync_cnt;
    int          s_trig, s_str, s_evf, s_evp, s_snp, s_fs, s_sync, s_words;
    logic [3:0]  ex [4]  = '{4'b0001, 4'b0110, 4'b0010, 4'b0101};
    logic [15:0] smp [4] = '{16'h04B0, 16'h02BC, 16'h012C, 16'h03E8};

    always #10 sys_clk = ~sys_clk;

    ttd_detector ttd_detector_inst (
        .sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sample_in, .ext_sync, .feature_state,
        .trigger, .strobe, .sync_mark, .delayed_waveform_out, .store_waveform,
        .store_valid, .ev_feature, .ev_pass, .snip_req, .irq
    );

    ttd_store_model ttd_store_model_inst (
        .sys_clk, .reset, .store_valid, .store_waveform, .words, .first_word
    );

    // ****************
    // monitors and tasks
    // ****************
    initial
    begin
        {err_count, cmp_count, run, last_run, dbl, trig_cnt, str_cnt} = '0;
        {evf_cnt, evp_cnt, snp_cnt, fs_cnt, sync_cnt} = '0;
    end

    always @(posedge sys_clk)
    begin
        tprev    <= trigger;
        dbl      <= dbl + int'(trigger & tprev);
        trig_cnt <= trig_cnt + int'(trigger);
        str_cnt  <= str_cnt + int'(strobe);
        evf_cnt  <= evf_cnt + int'(ev_feature);
        evp_cnt  <= evp_cnt + int'(ev_pass);
        snp_cnt  <= snp_cnt + int'(snip_req);
        fs_cnt   <= fs_cnt + int'(feature_state);
        sync_cnt <= sync_cnt + int'(sync_mark);
        run      <= strobe ? run + 1 : 0;
        if (!strobe && run != 0)
            last_run <= run;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rv      = prdata;
        sv      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic put(input logic [15:0] v, input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            sample_in <= {CHI, v};
        end
    endtask

    task automatic pulse(input int n);
        put(HI, n);
        put(16'h0000, 30);
    endtask

    task automatic mark();
        {s_trig, s_str, s_evf, s_evp} = {trig_cnt, str_cnt, evf_cnt, evp_cnt};
        {s_snp, s_fs, s_sync, s_words} = {snp_cnt, fs_cnt, sync_cnt, words};
    endtask

    task automatic lat(output int n);
        put(16'h0000, 40);
        put(16'h0ABC, 1);
        n = 0;
        while (delayed_waveform_out[15:0] !== 16'h0ABC && n < 200)
        begin
            put(16'h0000, 1);
            n++;
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #(1_000_000);
        err_count++;
        conclude();
    end

    // ****************
    // tests
    // ****************
    initial
    begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        xfer(1'b0, ADDR_CTRL, 32'h0);
        check(rv, 32'h0000_4000);
        xfer(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        check(32'(sv), 32'h1);
        xfer(1'b0, 12'h0FC, 32'h0);
        check(rv, 32'h0);
        check(32'(sv), 32'h1);
        xfer(1'b1, ADDR_THR_HI, 32'h03E8);
        xfer(1'b1, ADDR_THR_LO, 32'h01F4);
        xfer(1'b1, ADDR_RANGE, 32'h0014);
        xfer(1'b1, ADDR_OFFSET, 32'h0004);
        xfer(1'b1, ADDR_TM1, 32'h0004);
        xfer(1'b1, ADDR_TM2, 32'h0004);
        xfer(1'b0, ADDR_THR_HI, 32'h0);
        check(rv, 32'h03E8);
        for (int f = 0; f < 4; f++)
        begin
            xfer(1'b1, ADDR_CTRL, HID | 32'(f));
            for (int j = 0; j < (f < 2 ? 4 : 3); j++)
            begin
                put(smp[j], 4);
                check(32'(feature_state), 32'(ex[f][j]));
            end
        end
        xfer(1'b1, ADDR_CTRL, HID | 32'(TTD_RISING));
        for (int i = 0; i < 6; i++)
            put(16'h0100 + 16'(i << 6), 1);
        check(32'(feature_state), 32'h1);
        put(16'h0240, 4);
        check(32'(feature_state), 32'h0);
        xfer(1'b1, ADDR_CTRL, HID | 32'(TTD_FALLING));
        for (int i = 0; i < 6; i++)
            put(16'h0400 - 16'(i << 6), 1);
        check(32'(feature_state), 32'h1);
        xfer(1'b1, ADDR_CTRL, HID | 32'h20);
        put(16'h0000, 4);
        check(32'(feature_state), 32'h1);
        xfer(1'b1, ADDR_CTRL, HID | EVX);
        xfer(1'b1, ADDR_IRQ_MSK, 32'h7);
        put(16'h0000, 30);
        xfer(1'b1, ADDR_IRQ_ST, 32'h7);
        mark();
        put(HI, 3);
        put(16'h0000, 3);
        pulse(3);
        check(32'(trig_cnt - s_trig), 32'h1);
        check(32'(last_run), 32'h14);
        check(32'(evp_cnt - s_evp), 32'h1);
        check(32'(snp_cnt - s_snp), 32'h1);
        check(32'(evf_cnt - s_evf), 32'h2);
        check(32'(words - s_words), 32'h14);
        check(first_word[63:32], CHI[47:16]);
        check(32'(irq), 32'h1);
        xfer(1'b0, ADDR_IRQ_ST, 32'h0);
        check(32'(rv[1:0]), 32'h3);
        xfer(1'b1, ADDR_IRQ_ST, 32'h7);
        put(16'h0000, 3);
        check(32'(irq), 32'h0);
        xfer(1'b1, ADDR_IRQ_MSK, 32'h0);
        pulse(3);
        check(32'(irq), 32'h0);
        xfer(1'b1, ADDR_IRQ_MSK, 32'h2);
        put(16'h0000, 3);
        check(32'(irq), 32'h1);
        xfer(1'b1, ADDR_CTRL, 32'h0);
        mark();
        pulse(3);
        check(32'(trig_cnt - s_trig), 32'h0);
        check(32'(str_cnt - s_str), 32'h0);
        xfer(1'b1, ADDR_CTRL, ENA);
        mark();
        pulse(3);
        check(32'(trig_cnt - s_trig), 32'h1);
        xfer(1'b1, ADDR_CTRL, HID | DEN);
        mark();
        pulse(2);
        check(32'(fs_cnt - s_fs), 32'h0);
        pulse(3);
        check(32'(fs_cnt != s_fs), 32'h1);
        xfer(1'b1, ADDR_CTRL, HID | HYS);
        xfer(1'b1, ADDR_IRQ_ST, 32'h7);
        mark();
        put(16'h0000, 10);
        pulse(8);
        check(32'(trig_cnt - s_trig), 32'h1);
        mark();
        pulse(2);
        check(32'(trig_cnt - s_trig), 32'h0);
        xfer(1'b0, ADDR_IRQ_ST, 32'h0);
        check(32'(rv[2]), 32'h1);
        lat(nh);
        xfer(1'b1, ADDR_CTRL, HID);
        lat(nn);
        check(32'(nh - nn), 32'h4);
        check(32'(nn >= 24 && nn <= 27), 32'h1);
        for (int m = 0; m < 3; m++)
        begin
            xfer(1'b1, ADDR_CTRL, HID | (32'(m) << 8));
            put(16'h0000, 30);
            mark();
            ext_sync <= 1'b1;
            put(16'h0000, 3);
            ext_sync <= 1'b0;
            put(16'h0000, 5);
            check(32'(sync_cnt != s_sync), 32'(m == 1));
            pulse(3);
            check(32'(sync_cnt != s_sync), 32'(m != 2));
        end
        xfer(1'b0, ADDR_STATUS, 32'h0);
        check(rv, 32'(TTD_IDLE));
        check(32'(dbl), 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
